// File: hdl/adc_seq_pkg.sv
/*
  Constants, clock selections and trigger selections of the conversion sequencer.
  Assumes a single 250 MHz core clock; the analog comparator sits outside.
*/
// Function
// [R1] The converter runs only while converter_on is set.
// [R2] Writing conversion_go while enabled starts a conversion.
// [R3] A selected external trigger also starts a conversion.
// [R4] Software never sets conversion_go in the same write that enables the converter.
// [R5] At completion: clear conversion_go, set conversion_done_flag, load the result.
// [R6] Sleep conversion only on the RC clock, whose start waits one extra instruction.
// [R7] Completion in Sleep with done_irq_enable set requests wake-up.
// [R8] Completion in Sleep without done_irq_enable powers the converter down, converter_on kept.
// [R9] Sleep on a non-RC clock aborts the conversion and powers down, converter_on kept.
// [R10] Triggers arriving in Sleep are held pending until Sleep ends.
// [R11] Rising edge of the selected trigger sets conversion_go by hardware.
// [R12] trigger_select routes one hardware source to the edge detector.
// [R13] Software keeps trigger timing within converter timing needs.
// [R14] Software waits the acquisition time after channel changes.
// [R15] Software follows the recommended configure, enable, wait, start, read, clear order.
// [R16] conversion_done_flag is set at every completion regardless of interrupt enable.
// [R17] Only software clears conversion_done_flag.
// [R18] justify_select 1 right-justifies, 0 left-justifies the ten-bit result.
// [R19] The trigger is synchronised and edge-detected, one start per edge.
// [R20] At most one trigger is held pending in Sleep; starting clears it.
package adc_seq_pkg;
  localparam int          RES_BITS      = 10;
  localparam int          CONV_TAD      = 11;   // Sample plus ten bit decisions
  localparam int          CORE_MHZ      = 250;
  localparam int          INSTR_NS      = 16;   // One instruction cycle
  localparam int          INSTR_CYC     = (INSTR_NS * CORE_MHZ + 999) / 1000;
  localparam int          RC_TAD_NS     = 1000;
  localparam int          RC_DIV        = (RC_TAD_NS * CORE_MHZ) / 1000;
  localparam logic [2:0]  CS_RC_MASK    = 3'h3; // Codes x11 pick the RC clock
  localparam logic [3:0]  ACT_NONE      = 4'h0;
  localparam int          TRIG_SRCS     = 16;
  localparam logic [15:0] RESULT_RESET  = 16'h0000;
endpackage : adc_seq_pkg

// File: hdl/adc_tad_divider.sv
/*
  Conversion clock enable divider: one-cycle pulse per conversion clock period.
  Assumes the core clock and a synchronous reset; restarted at each conversion start.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_tad_divider
  import adc_seq_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_restart,
  input  wire logic [2:0] i_clk_sel,
  output logic            o_tad_tick
);
  typedef struct packed {
    logic [7:0] cnt;
  } div_state_t;

  div_state_t st_reg;
  div_state_t st_next;
  logic [7:0] limit;

  // ==========================================================
  // Divide ratio
  always_comb
  begin
    unique case (i_clk_sel)
      3'h0:    limit = 8'h01;
      3'h4:    limit = 8'h03;
      3'h1:    limit = 8'h07;
      3'h5:    limit = 8'h0F;
      3'h2:    limit = 8'h1F;
      3'h6:    limit = 8'h3F;
      default: limit = 8'(RC_DIV - 1);
    endcase
  end

  always_comb
  begin
    st_next = st_reg;
    if (i_restart || st_reg.cnt >= limit)
      st_next.cnt = 8'h00;
    else
      st_next.cnt = st_reg.cnt + 8'h01;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign o_tad_tick = !i_restart && st_reg.cnt >= limit;
endmodule : adc_tad_divider
`default_nettype wire

// File: hdl/adc_conversion_sequencer.sv
/*
  Conversion sequencer: enable, software and hardware start, completion, Sleep handling.
  Assumes software writes arrive as one-cycle strobes and the comparator result is steady.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic                    i_core_clk,
  input  wire logic                    i_sys_rst,
  input  wire logic                    i_converter_on,
  input  wire logic                    i_go_write,
  input  wire logic                    i_go_write_val,
  input  wire logic                    i_flag_clear,
  input  wire logic                    i_done_irq_enable,
  input  wire logic                    i_justify_select,
  input  wire logic [2:0]              i_clk_sel,
  input  wire logic [3:0]              i_trigger_select,
  input  wire logic [adc_seq_pkg::TRIG_SRCS-1:0] i_trig_src,
  input  wire logic                    i_sleep,
  input  wire logic [adc_seq_pkg::RES_BITS-1:0]  i_sample_data,
  output logic                         o_conversion_go,
  output logic                         o_conversion_done_flag,
  output logic [15:0]                  o_result_register,
  output logic                         o_wake_req,
  output logic                         o_analog_powered,
  output logic                         o_sample_hold
);
  import adc_seq_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_DELAY, S_CONV} phase_t;

  typedef struct packed {
    phase_t     phase;
    logic       go;
    logic       done_flag;
    logic [15:0] result;
    logic       sync1;
    logic       sync2;
    logic       trig_prev;
    logic       pending;
    logic       wake;
    logic       powered_down;
    logic [7:0] dly;
    logic [3:0] tads;
  } seq_state_t;

  seq_state_t st_reg;
  seq_state_t st_next;
  logic       tick;
  logic       rc_clk;
  logic       trig_sel;
  logic       trig_edge;
  logic       start_req;
  logic       restart;

  // ==========================================================
  // Trigger routing and edge detection
  assign rc_clk    = (i_clk_sel & CS_RC_MASK) == CS_RC_MASK;
  assign trig_sel  = (i_trigger_select != ACT_NONE) && i_trig_src[i_trigger_select]; // [R12]
  assign trig_edge = st_reg.sync2 && !st_reg.trig_prev;                             // [R19]

  always_comb
  begin
    st_next           = st_reg;
    st_next.sync1     = trig_sel;
    st_next.sync2     = st_reg.sync1;
    st_next.trig_prev = st_reg.sync2;
    st_next.wake      = 1'b0;
    start_req         = 1'b0;
    restart           = 1'b0;
    if (!i_sleep)
      st_next.powered_down = 1'b0;
    // Edges in Sleep merge into one pending request
    if (i_converter_on && trig_edge && i_sleep)
      st_next.pending = 1'b1;                                                        // [R10] [R20]
    if (i_converter_on && st_reg.phase == S_IDLE && !st_reg.powered_down)
    begin
      if (i_go_write && i_go_write_val)
        start_req = 1'b1;                                                            // [R2]
      else if (!i_sleep && (trig_edge || st_reg.pending))
        start_req = 1'b1;                                                            // [R3] [R11] [R10]
    end
    if (start_req)
    begin
      st_next.go      = 1'b1;                                                        // [R11]
      st_next.pending = 1'b0;                                                        // [R20]
      st_next.dly     = rc_clk ? 8'(INSTR_CYC) : 8'h00;                             // [R6]
      st_next.phase   = S_DELAY;
    end
    unique case (st_reg.phase)
      S_IDLE: ;
      S_DELAY:
      begin
        if (st_reg.dly == 8'h00)
        begin
          restart       = 1'b1;
          st_next.tads  = 4'h0;
          st_next.phase = S_CONV;
        end
        else
          st_next.dly = st_reg.dly - 8'h01;
      end
      S_CONV:
      begin
        if (tick)
        begin
          if (st_reg.tads == 4'(CONV_TAD - 1))
          begin
            st_next.phase     = S_IDLE;
            st_next.go        = 1'b0;                                                // [R5]
            st_next.done_flag = 1'b1;                                                // [R5] [R16]
            st_next.result    = i_justify_select
                              ? {6'h00, i_sample_data}
                              : {i_sample_data, 6'h00};                              // [R18]
            if (i_sleep && i_done_irq_enable)
              st_next.wake = 1'b1;                                                   // [R7]
            else if (i_sleep)
              st_next.powered_down = 1'b1;                                           // [R8]
          end
          else
            st_next.tads = st_reg.tads + 4'h1;
        end
      end
    endcase
    // Sleep on a system-derived clock kills the conversion
    if (i_sleep && !rc_clk && st_reg.phase != S_IDLE)
    begin
      st_next.phase        = S_IDLE;
      st_next.go           = 1'b0;
      st_next.powered_down = 1'b1;                                                   // [R9]
    end
    // Disabling drops the conversion, go and any pending trigger; the flag and the result are kept for software
    if (!i_converter_on)
    begin
      st_next.phase   = S_IDLE;                                                      // [R1]
      st_next.go      = 1'b0;
      st_next.pending = 1'b0;
    end
    // Completion set wins over a simultaneous software clear
    if (i_flag_clear && !(st_reg.phase == S_CONV && tick && st_reg.tads == 4'(CONV_TAD - 1)))
      st_next.done_flag = 1'b0;                                                      // [R17]
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      st_reg        <= '0;
      st_reg.phase  <= S_IDLE;
      st_reg.result <= RESULT_RESET;
    end
    else
      st_reg <= st_next;
  end

  adc_tad_divider u_div (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_restart  (restart),
    .i_clk_sel  (i_clk_sel),
    .o_tad_tick (tick)
  );

  assign o_conversion_go        = st_reg.go;
  assign o_conversion_done_flag = st_reg.done_flag;
  assign o_result_register      = st_reg.result;
  assign o_wake_req             = st_reg.wake;
  assign o_analog_powered       = i_converter_on && !st_reg.powered_down;            // [R8] [R9]
  assign o_sample_hold          = st_reg.phase == S_CONV;

  // ==========================================================
  // Checks
  chk_go_needs_on: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !i_converter_on |=> !o_conversion_go) else $error("go set while disabled"); // [R1]
  chk_sw_start: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_converter_on && st_reg.phase == S_IDLE && !st_reg.powered_down && i_go_write && i_go_write_val)
    |=> o_conversion_go) else $error("software start missed"); // [R2]
  chk_done_sets_flag: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    $fell(o_conversion_go) && !$past(i_sleep) && $past(i_converter_on) |-> o_conversion_done_flag)
    else $error("flag not set at completion"); // [R5]
  chk_rc_delay: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (start_req && rc_clk && i_converter_on && !i_sleep) |=> !o_sample_hold [*4])
    else $error("rc start not delayed"); // [R6]
  chk_wake_req: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_wake_req |-> $past(i_sleep) && $past(i_done_irq_enable) && o_conversion_done_flag)
    else $error("bad wake request"); // [R7]
  chk_sleep_abort: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_sleep && !rc_clk && o_sample_hold && i_converter_on) |=> !o_sample_hold && !o_analog_powered)
    else $error("no abort in sleep"); // [R9]
  chk_pending_wait: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (st_reg.pending && i_sleep) |-> !start_req || (i_go_write && i_go_write_val))
    else $error("pending started in sleep"); // [R10]
  chk_justify: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    $fell(o_conversion_go) && $past(st_reg.phase) == S_CONV && $past(i_justify_select)
    && $past(i_converter_on) && $past(tick) && $past(st_reg.tads) == 4'(CONV_TAD - 1)
    |-> o_result_register[15:10] == 6'h00) else $error("right justify wrong"); // [R18]
endmodule : adc_conversion_sequencer
`default_nettype wire

// File: sim/trig_src_model.sv
/*
  Hardware trigger sources seen by the sequencer: sixteen level lines.
  Assumes the bench names one watched source and its level; the rest toggle freely.
*/
`timescale 1ns/1ps
`default_nettype none
module trig_src_model
(
  input  wire logic       i_core_clk,
  input  wire logic [3:0] i_watch_idx,
  input  wire logic       i_watch_level,
  output logic [15:0]     o_src
);
  // ====================
  // Sources
  // Unwatched lines carry noise, so a wrong route starts stray conversions
  logic [15:0] noise;

  always @(posedge i_core_clk)
  begin
    noise = 16'($urandom);
    noise[i_watch_idx] = i_watch_level;
    o_src <= noise;
  end
endmodule : trig_src_model
`default_nettype wire

// File: sim/adc_conversion_sequencer_tb.sv
/*
  Self-checking bench of the conversion sequencer.
  Assumes the trigger source model; results are checked when conversion_go falls.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_tb;
  import adc_seq_pkg::*;
  typedef struct packed {logic [15:0] res; logic flag;} note_t;
  logic           clk, rst, on, gw, fclr, irq, just, slp, lvl, go, flag, wake, pwr, sh;
  logic           go_q   = 1'b0;
  logic [15:0]    wake_n = 16'h0000;
  logic [2:0]     cs;
  logic [3:0]     tsel, widx;
  logic [9:0]     dat;
  logic [15:0]    src, res, last;
  note_t          q[$];
  note_t          n;
  int             err_count, n_compared, i;

  adc_conversion_sequencer adc_conversion_sequencer_inst (.i_core_clk(clk), .i_sys_rst(rst),
    .i_converter_on(on), .i_go_write(gw), .i_go_write_val(1'b1), .i_flag_clear(fclr),
    .i_done_irq_enable(irq), .i_justify_select(just), .i_clk_sel(cs), .i_trigger_select(tsel),
    .i_trig_src(src), .i_sleep(slp), .i_sample_data(dat), .o_conversion_go(go),
    .o_conversion_done_flag(flag), .o_result_register(res), .o_wake_req(wake),
    .o_analog_powered(pwr), .o_sample_hold(sh));
  trig_src_model trig_src_model_inst (.i_core_clk(clk), .i_watch_idx(widx), .i_watch_level(lvl), .o_src(src));

  // ====================
  // Checking
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("errors=%0d compared=%0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  always @(posedge clk)
  begin
    go_q <= go;
    if (wake === 1'b1)
      wake_n <= wake_n + 16'h0001;
    // Sampling may only happen inside a running conversion
    if (sh !== 1'b0 && go !== 1'b1)
      check({15'h0, sh}, 16'h0);
    if (go_q === 1'b1 && go === 1'b0)
    begin
      if (q.size() == 0)
        check(16'h1, 16'h0);
      else
      begin
        n = q.pop_front();
        check(res, n.res);
        check({15'h0, flag}, {15'h0, n.flag});
      end
    end
  end

  // ====================
  // Stimulus
  task automatic prep(input logic [2:0] c, input logic j, input logic ab);
    logic [9:0] d;
    d = 10'($urandom);
    @(posedge clk);
    dat <= d;
    cs <= c;
    just <= j;
    fclr <= 1;
    @(posedge clk);
    fclr <= 0;
    if (!ab)
      last = j ? {6'h0, d} : {d, 6'h0};
    q.push_back({last, !ab});
  endtask : prep

  task automatic sw_go(input logic s);
    gw <= 1;
    @(posedge clk);
    gw <= 0;
    slp <= s;
  endtask : sw_go

  // Bounded wait: a stuck conversion ends the wait, the watchdog ends the run
  task automatic wait_idle;
    @(negedge clk);
    for (i = 0; i < 8 && go !== 1'b1; i++) @(negedge clk);
    check({15'h0, go}, 16'h1);
    for (i = 0; i < 4000 && go !== 1'b0; i++) @(negedge clk);
    repeat (3) @(posedge clk);
  endtask : wait_idle

  initial
  begin
    clk = 0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    #200000;
    err_count++;
    report_and_stop();
  end

  initial
  begin
    void'($urandom(32'h559F));
    {rst, on, gw, fclr, irq, just, slp, lvl} = 8'h80;
    {cs, tsel, widx, dat, last} = '0;
    repeat (3) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    sw_go(0);
    repeat (3) @(negedge clk);
    check({15'h0, go}, 16'h0);
    @(posedge clk);
    on <= 1;
    @(posedge clk);
    for (int k = 0; k < 7; k++)
      if (k != 3)
      begin
        prep(3'(k), k[0], 0);
        sw_go(0);
        wait_idle();
      end
    prep(3'h6, 0, 1);
    sw_go(1);
    wait_idle();
    check({15'h0, pwr}, 16'h0);
    slp <= 0;
    irq <= 1;
    prep(3'h3, 1, 0);
    sw_go(1);
    wait_idle();
    check(wake_n, 16'h1);
    {slp, irq} <= 2'h0;
    prep(3'h7, 0, 0);
    sw_go(1);
    wait_idle();
    check({wake_n[14:0], pwr}, 16'h2);
    slp <= 0;
    widx <= 4'($urandom_range(15, 1));
    repeat (3) @(posedge clk);
    tsel <= widx;
    prep(3'h0, 1, 0);
    lvl <= 1;
    wait_idle();
    {lvl, slp} <= 2'h1;
    repeat (4) @(posedge clk);
    prep(3'h0, 0, 0);
    lvl <= 1;
    repeat (4) @(posedge clk) lvl <= ~lvl;
    repeat (20) @(negedge clk);
    check({15'h0, go}, 16'h0);
    @(posedge clk);
    slp <= 0;
    wait_idle();
    repeat (50) @(posedge clk);
    check(16'(q.size()), 16'h0);
    report_and_stop();
  end
endmodule : adc_conversion_sequencer_tb
`default_nettype wire
